// ### shared/eisp_pkg.sv
// Register map, field layout and encodings of the external interrupt status and priority block
package eisp_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int PIN_COUNT   = 8;
	localparam int PRIO_REGS   = 10;
	localparam int PRIO_FIELDS = 4;
	localparam int PRIO_W      = 4;
	localparam int REG_W       = 16;
	localparam int EVT_W       = 9;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS     = 8'h00; // ext_int_status
	localparam logic [7:0] OFS_CTL_ONE    = 8'h04; // int_control_one: 1 = edge mode per pin
	localparam logic [7:0] OFS_CTL_TWO    = 8'h08; // int_control_two: edge select per pin
	localparam logic [7:0] OFS_EVT_STATUS = 8'h0c; // sticky event bits, write one to clear
	localparam logic [7:0] OFS_EVT_MASK   = 8'h10; // event enables
	localparam logic [7:0] OFS_PRIO_BASE  = 8'h14; // int_priority_a, then b..j every 4 bytes
	localparam logic [7:0] OFS_PRIO_LAST  = 8'h38; // int_priority_j

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int FLAG_TOP      = 7;  // pin 0 flag sits here, pin n at FLAG_TOP - n
	localparam int EVT_BAD_SEL   = 8;  // event bit: illegal edge select written
	localparam int SEL_TOP       = 15; // pin n select at SEL_TOP-2n : SEL_TOP-2n-1
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [7:0]  RST_REG8  = 8'h00;
	localparam logic [8:0]  RST_EVT   = 9'h000;

	// ----------------------------------------------------------------
	// Edge select encodings; 2'h3 is not permitted
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EDGE_FALL = 2'h0,
		EDGE_RISE = 2'h1,
		EDGE_BOTH = 2'h2
	} edge_sel_t;
	localparam logic [1:0] EDGE_ILLEGAL = 2'h3;

endpackage

// ### rtl/irq_detect.sv
// Request detector for one active-low external interrupt pin
`timescale 1ns/100ps
module irq_detect
	import eisp_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Pin and mode
	input  wire logic       pin_n_i,
	input  wire logic       edge_mode_i,
	input  wire logic [1:0] edge_sel_i,
	// Detection result
	output logic            set_o,
	output logic            pin_high_o
);

	// ----------------------------------------------------------------
	// State: previous pin level, reset high so no false edge at start
	// ----------------------------------------------------------------
	typedef struct packed {
		logic prev;
	} det_state_t;

	det_state_t q;
	det_state_t d;
	logic       fall;
	logic       rise;

	// Edge and level decode of the request condition
	always_comb begin
		d      = q;
		d.prev = pin_n_i;
		fall   = q.prev & ~pin_n_i;
		rise   = ~q.prev & pin_n_i;
		set_o  = 1'b0;
		if (!edge_mode_i) begin
			set_o = ~pin_n_i; // R5
		end else begin
			unique case (edge_sel_i)
				EDGE_FALL: set_o = fall; // R15
				EDGE_RISE: set_o = rise; // R15
				EDGE_BOTH: set_o = fall | rise; // R15
				default:   set_o = 1'b0; // Illegal code never stored
			endcase
		end
		pin_high_o = pin_n_i;
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q.prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

endmodule

// ### rtl/ext_int_status_priority.sv
// External interrupt request flags, priority registers and APB register file
`timescale 1ns/100ps

// Behaviour
// R1 - Sixteen-bit status register for eight pins
// R2 - Pin 0 at bit 7; reset zero
// R3 - Status bits 15 to 8 read zero
// R4 - Software writes zero to reserved bits
// R5 - Selected request condition sets pin flag
// R6 - Write zero after reading one clears
// R7 - Level mode: exception clears if pin high
// R8 - Edge mode: exception processing clears flag
// R9 - Transfer start clears flag when select zero
// R10 - Ten sixteen-bit read/write priority registers
// R11 - Four 4-bit fields per priority register
// R12 - Field is binary level, 0 to 15
// R13 - Priority bits reset zero, read/write
// R14 - Software keeps unassigned fields at zero
// R15 - Edge select: fall, rise, both; 11 illegal
// R16 - Other writes leave flag; set wins
module ext_int_status_priority
	import eisp_pkg::*;
(
	// Clock and reset
	input  wire logic                         CLOCK_I,
	input  wire logic                         RESET_I,
	// APB slave
	input  wire logic                         PSEL_I,
	input  wire logic                         PENABLE_I,
	input  wire logic                         PWRITE_I,
	input  wire logic [7:0]                   PADDR_I,
	input  wire logic [31:0]                  PWDATA_I,
	output logic      [31:0]                  PRDATA_O,
	output logic                              PREADY_O,
	output logic                              PSLVERR_O,
	// External request pins, active low
	input  wire logic [PIN_COUNT-1:0]         EXT_REQUEST_PIN_N_I,
	// CPU core and transfer controller
	input  wire logic [PIN_COUNT-1:0]         EXC_ACCEPT_I,
	input  wire logic [PIN_COUNT-1:0]         DTC_START_I,
	input  wire logic [PIN_COUNT-1:0]         INT_DISABLE_SELECT_I,
	// Flags, priorities and interrupt
	output logic      [PIN_COUNT-1:0]         EXT_PIN_REQUEST_FLAG_O,
	output logic      [PRIO_REGS*REG_W-1:0]   PRIORITY_O,
	output logic                              IRQ_O
);

	// ----------------------------------------------------------------
	// State of the whole block
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [PIN_COUNT-1:0]            flag;
		logic [PIN_COUNT-1:0]            armed;
		logic [PIN_COUNT-1:0]            ctl_one;
		logic [REG_W-1:0]                ctl_two;
		logic [EVT_W-1:0]                evt;
		logic [EVT_W-1:0]                mask;
		logic [PRIO_REGS-1:0][REG_W-1:0] prio;
		logic [31:0]                     prdata;
		logic                            pready;
		logic                            pslverr;
		logic                            irq;
	} state_t;

	state_t               q;
	state_t               d;
	logic [PIN_COUNT-1:0] set_req;
	logic [PIN_COUNT-1:0] pin_high;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Pin flags appear in reverse order in the status word
	function automatic logic [7:0] flags_to_word(input logic [PIN_COUNT-1:0] f);
		logic [7:0] w;
		w = 8'h00;
		for (int n = 0; n < PIN_COUNT; n++) begin
			w[FLAG_TOP-n] = f[n]; // R2
		end
		return w;
	endfunction

	// Priority register index for an address, valid only inside the range
	function automatic logic [3:0] prio_index(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - OFS_PRIO_BASE;
		return rel[5:2];
	endfunction

	// True when the address selects one of the priority registers
	function automatic logic is_prio(input logic [7:0] a);
		return (a >= OFS_PRIO_BASE) && (a <= OFS_PRIO_LAST) && (a[1:0] == 2'h0);
	endfunction

	// True for every mapped register
	function automatic logic is_mapped(input logic [7:0] a);
		return (a == OFS_STATUS) || (a == OFS_CTL_ONE) || (a == OFS_CTL_TWO)
			|| (a == OFS_EVT_STATUS) || (a == OFS_EVT_MASK) || is_prio(a);
	endfunction

	// ----------------------------------------------------------------
	// Per-pin request detectors
	// ----------------------------------------------------------------
	for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
		irq_detect u_detect (
			.clk_i       (CLOCK_I),
			.rst_i       (RESET_I),
			.pin_n_i     (EXT_REQUEST_PIN_N_I[n]),
			.edge_mode_i (q.ctl_one[n]),
			.edge_sel_i  (q.ctl_two[SEL_TOP-2*n -: 2]),
			.set_o       (set_req[n]),
			.pin_high_o  (pin_high[n])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic                 setup;
	logic                 access;
	logic                 wr;
	logic                 rd;
	logic [PIN_COUNT-1:0] hw_clr;
	logic [PIN_COUNT-1:0] sw_clr;
	logic [EVT_W-1:0]     new_evt;
	logic [EVT_W-1:0]     evt_w1c;
	logic [1:0]           sel_new;
	logic                 bad_sel;
	logic [3:0]           pidx;

	always_comb begin
		d       = q;
		setup   = PSEL_I & ~PENABLE_I;
		access  = PSEL_I & PENABLE_I & q.pready;
		wr      = access & PWRITE_I;
		rd      = access & ~PWRITE_I;
		hw_clr  = '0;
		sw_clr  = '0;
		new_evt = RST_EVT;
		evt_w1c = RST_EVT;
		sel_new = 2'h0;
		bad_sel = 1'b0;
		pidx    = prio_index(PADDR_I);

		// Setup phase: read data and error are captured so that the
		// outputs come from flops; this costs no wait state
		d.pready = 1'b0;
		if (setup) begin
			d.pready  = 1'b1;
			d.pslverr = ~is_mapped(PADDR_I);
			d.prdata  = 32'h0000_0000;
			if (PADDR_I == OFS_STATUS) begin
				d.prdata = {24'h00_0000, flags_to_word(q.flag)}; // R1 R3
			end else if (PADDR_I == OFS_CTL_ONE) begin
				d.prdata = {24'h00_0000, q.ctl_one};
			end else if (PADDR_I == OFS_CTL_TWO) begin
				d.prdata = {16'h0000, q.ctl_two};
			end else if (PADDR_I == OFS_EVT_STATUS) begin
				d.prdata = {23'h00_0000, q.evt};
			end else if (PADDR_I == OFS_EVT_MASK) begin
				d.prdata = {23'h00_0000, q.mask};
			end else if (is_prio(PADDR_I)) begin
				d.prdata = {16'h0000, q.prio[pidx]}; // R10 R13
			end
		end

		// Hardware clear conditions per pin
		for (int n = 0; n < PIN_COUNT; n++) begin
			// Level mode only lets the exception clear once the pin is back high,
			// otherwise the still-active level would be lost
			if (EXC_ACCEPT_I[n] && !q.ctl_one[n] && pin_high[n]) begin
				hw_clr[n] = 1'b1; // R7
			end
			if (EXC_ACCEPT_I[n] && q.ctl_one[n]) begin
				hw_clr[n] = 1'b1; // R8
			end
			if (DTC_START_I[n] && !INT_DISABLE_SELECT_I[n]) begin
				hw_clr[n] = 1'b1; // R9
			end
		end

		// Software clear: a zero only counts when that flag was read as one
		if (wr && PADDR_I == OFS_STATUS) begin
			for (int n = 0; n < PIN_COUNT; n++) begin
				sw_clr[n] = q.armed[n] & ~PWDATA_I[FLAG_TOP-n]; // R6 R16
			end
		end

		// Arming: remember flags that software saw as one
		if (rd && PADDR_I == OFS_STATUS) begin
			for (int n = 0; n < PIN_COUNT; n++) begin
				d.armed[n] = q.armed[n] | q.prdata[FLAG_TOP-n]; // R6
			end
		end else if (wr && PADDR_I == OFS_STATUS) begin
			d.armed = '0; // Each read arms one clearing write only
		end

		// Flag update: a new request beats any clear in the same cycle
		for (int n = 0; n < PIN_COUNT; n++) begin
			d.flag[n] = set_req[n] | (q.flag[n] & ~hw_clr[n] & ~sw_clr[n]); // R5 R16
		end
		d.armed = d.armed & d.flag;

		// Control and priority writes
		if (wr) begin
			if (PADDR_I == OFS_CTL_ONE) begin
				d.ctl_one = PWDATA_I[PIN_COUNT-1:0];
			end
			if (PADDR_I == OFS_CTL_TWO) begin
				// An illegal select keeps the old field and raises an event
				for (int n = 0; n < PIN_COUNT; n++) begin
					sel_new = PWDATA_I[SEL_TOP-2*n -: 2];
					if (sel_new == EDGE_ILLEGAL) begin
						bad_sel = 1'b1; // R15
					end else begin
						d.ctl_two[SEL_TOP-2*n -: 2] = sel_new; // R15
					end
				end
			end
			if (PADDR_I == OFS_EVT_MASK) begin
				d.mask = PWDATA_I[EVT_W-1:0];
			end
			if (PADDR_I == OFS_EVT_STATUS) begin
				evt_w1c = PWDATA_I[EVT_W-1:0];
			end
			if (is_prio(PADDR_I)) begin
				d.prio[pidx] = PWDATA_I[REG_W-1:0]; // R10 R11 R13
			end
		end

		// Sticky events; set wins over the write-one clear
		new_evt[PIN_COUNT-1:0] = set_req & ~q.flag;
		new_evt[EVT_BAD_SEL]   = bad_sel;
		d.evt = (q.evt & ~evt_w1c) | new_evt;
		d.irq = |(d.evt & d.mask);
	end

	// ----------------------------------------------------------------
	// State register, synchronous reset to all zero
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			q.flag    <= RST_REG8; // R2
			q.armed   <= RST_REG8;
			q.ctl_one <= RST_REG8;
			q.ctl_two <= RST_REG16;
			q.evt     <= RST_EVT;
			q.mask    <= RST_EVT;
			q.prio    <= '0; // R13
			q.prdata  <= 32'h0000_0000;
			q.pready  <= 1'b0;
			q.pslverr <= 1'b0;
			q.irq     <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------------------------------
	assign PRDATA_O               = q.prdata;
	assign PREADY_O               = q.pready;
	assign PSLVERR_O              = q.pslverr;
	assign EXT_PIN_REQUEST_FLAG_O = q.flag;
	assign PRIORITY_O             = q.prio; // R12
	assign IRQ_O                  = q.irq;

endmodule

// ### dv/eisp_sva.sv
// Checker for the interrupt status and priority block
`timescale 1ns/100ps
module eisp_sva
	import eisp_pkg::*;
(
	// Clock, reset and APB
	input wire logic         CLOCK_I,
	input wire logic         RESET_I,
	input wire logic         PSEL_I,
	input wire logic         PENABLE_I,
	input wire logic         PWRITE_I,
	input wire logic [7:0]   PADDR_I,
	input wire logic [31:0]  PWDATA_I,
	input wire logic [31:0]  PRDATA_O,
	input wire logic         PREADY_O,
	input wire logic         PSLVERR_O,
	// Pins, core and results
	input wire logic [7:0]   EXT_REQUEST_PIN_N_I,
	input wire logic [7:0]   EXC_ACCEPT_I,
	input wire logic [7:0]   DTC_START_I,
	input wire logic [7:0]   INT_DISABLE_SELECT_I,
	input wire logic [7:0]   EXT_PIN_REQUEST_FLAG_O,
	input wire logic [159:0] PRIORITY_O,
	input wire logic         IRQ_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	wire logic        done = PSEL_I & PENABLE_I & PREADY_O;
	wire logic        sts_wr = done & PWRITE_I & (PADDR_I == OFS_STATUS);
	wire logic [15:0] wlo = PWDATA_I[15:0];
	sequence s_setup;
		PSEL_I & !PENABLE_I;
	endsequence
	// Status read showing pin 0 set, then a write clearing it
	sequence s_rd1;
		done & !PWRITE_I & (PADDR_I == OFS_STATUS) & PRDATA_O[7] & EXT_REQUEST_PIN_N_I[0];
	endsequence
	sequence s_wr0;
		sts_wr & !PWDATA_I[7] & EXT_REQUEST_PIN_N_I[0];
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_ready;
		s_setup |=> PREADY_O ##1 !PREADY_O;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
	property p_upper;
		done & !PWRITE_I & (PADDR_I == OFS_STATUS) |-> PRDATA_O[31:8] == 24'h0;
	endproperty
	a_upper: assert property (p_upper) else $error("status upper bits not zero");
	// Pin held high, so no set can mask the clear
	property p_rdclr;
		s_rd1 ##1 EXT_REQUEST_PIN_N_I[0] [*2] ##1 s_wr0 |=> !EXT_PIN_REQUEST_FLAG_O[0];
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("armed clear failed");
	property p_hold;
		EXT_PIN_REQUEST_FLAG_O[0] & !EXC_ACCEPT_I[0] & !DTC_START_I[0] & !sts_wr |=> EXT_PIN_REQUEST_FLAG_O[0];
	endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without cause");
	property p_exc;
		EXT_REQUEST_PIN_N_I[5] [*2] ##0 EXC_ACCEPT_I[5] |=> !EXT_PIN_REQUEST_FLAG_O[5];
	endproperty
	a_exc: assert property (p_exc) else $error("exception did not clear flag");
	property p_dtc;
		EXT_REQUEST_PIN_N_I[0] [*3] ##0 (DTC_START_I[0] & !INT_DISABLE_SELECT_I[0]) |=> !EXT_PIN_REQUEST_FLAG_O[0];
	endproperty
	a_dtc: assert property (p_dtc) else $error("transfer start did not clear flag");
	property p_reset;
		$fell(RESET_I) |-> (EXT_PIN_REQUEST_FLAG_O == 8'h0) && (PRIORITY_O == 160'h0) && !IRQ_O;
	endproperty
	a_reset: assert property (p_reset) else $error("state not zero after reset");
	property p_prio;
		done & PWRITE_I & (PADDR_I == OFS_PRIO_LAST) |=> PRIORITY_O[159:144] == $past(wlo);
	endproperty
	a_prio: assert property (p_prio) else $error("priority write lost");
	property p_slverr;
		done & (PADDR_I > OFS_PRIO_LAST) |-> PSLVERR_O & (PWRITE_I | (PRDATA_O == 32'h0));
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
endmodule

bind ext_int_status_priority eisp_sva u_sva (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .EXT_REQUEST_PIN_N_I(EXT_REQUEST_PIN_N_I),
	.EXC_ACCEPT_I(EXC_ACCEPT_I), .DTC_START_I(DTC_START_I), .INT_DISABLE_SELECT_I(INT_DISABLE_SELECT_I),
	.EXT_PIN_REQUEST_FLAG_O(EXT_PIN_REQUEST_FLAG_O), .PRIORITY_O(PRIORITY_O), .IRQ_O(IRQ_O));

// ### dv/cpu_model.sv
// Core model that accepts the exception of each pending pin
`timescale 1ns/100ps
module cpu_model (
	// Clock and control
	input  wire logic       clk_i,
	input  wire logic       ack_en_i,
	// Flags in, accept pulses out
	input  wire logic [7:0] flag_i,
	output logic      [7:0] accept_o = 8'h00
);
	// One pulse per pending flag; the gap lets the clear land before a repeat
	always @(posedge clk_i) begin
		accept_o <= {8{ack_en_i}} & flag_i & ~accept_o;
	end
endmodule

// ### dv/test_ext_int_status_priority.sv
// Self-checking bench for the interrupt status and priority block
`timescale 1ns/100ps
module test_ext_int_status_priority;
	import eisp_pkg::*;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic         clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ack = 0, rdy, err, irq, e;
	logic [7:0]   padr = 0, pins = 8'hff, data_transfer_controller = 0, dsel = 0, exc, flag;
	logic [31:0]  pwd = 0, prd, rd;
	logic [159:0] prio;
	logic [15:0]  pexp [10];
	int           errors = 0, checks = 0, seed = 32'h304cbd23;
	ext_int_status_priority DUT (.CLOCK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(err),
		.EXT_REQUEST_PIN_N_I(pins), .EXC_ACCEPT_I(exc), .DTC_START_I(data_transfer_controller), .INT_DISABLE_SELECT_I(dsel),
		.EXT_PIN_REQUEST_FLAG_O(flag), .PRIORITY_O(prio), .IRQ_O(irq));
	cpu_model u_cpu (.clk_i(clk), .ack_en_i(ack), .flag_i(flag), .accept_o(exc));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// APB transfer; holds the request until ready is seen at an edge, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (rdy !== 1'b1);
		rd = prd;
		e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Transfer start pulse for all pins with the given disable select
	task automatic start(input logic [7:0] s);
		dsel <= s;
		data_transfer_controller <= 8'hff;
		@(posedge clk);
		data_transfer_controller <= 8'h00;
		cyc(2);
	endtask
	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial forever #25 clk = ~clk;
	// Whole run needs a few hundred cycles; this is far beyond it
	initial begin
		#2000000;
		errors++;
		report_and_stop;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a <= 8'h38; a += 4) rdc(8'(a), 32'h0);
		apb(1'b0, 8'h3c, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(rd, 32'h0);
		tdone("reset");
		// Random priorities with junk in the upper half, one all-ones corner
		for (int i = 0; i < 10; i++) begin
			pexp[i] = (i == 0) ? 16'hffff : (i == 1) ? 16'h0f00 : 16'($random(seed));
			apb(1'b1, OFS_PRIO_BASE + 8'(4 * i), {16'ha5a5, pexp[i]});
		end
		for (int i = 0; i < 10; i++) begin
			rdc(OFS_PRIO_BASE + 8'(4 * i), {16'h0, pexp[i]});
			chk(prio[16 * i +: 16], pexp[i]);
		end
		tdone("priority");
		// Every edge mode on all pins, then both clear paths
		apb(1'b1, OFS_CTL_ONE, 32'hff);
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, OFS_CTL_TWO, {16'h0, {8{m[1:0]}}});
			pins <= 8'h00;
			cyc(4);
			chk(flag, (m != 1) ? 32'hff : 32'h0);
			ack <= 1'b1;
			cyc(4);
			ack <= 1'b0;
			chk(flag, 32'h0);
			pins <= 8'hff;
			cyc(4);
			chk(flag, (m != 0) ? 32'hff : 32'h0);
			start(8'hff);
			chk(flag, (m != 0) ? 32'hff : 32'h0);
			start(8'h00);
			chk(flag, 32'h0);
		end
		tdone("edges");
		// Illegal select keeps the old fields and raises a maskable event
		apb(1'b1, OFS_EVT_MASK, 32'h0);
		apb(1'b1, OFS_EVT_STATUS, 32'h1ff);
		apb(1'b1, OFS_CTL_TWO, 32'hffff);
		rdc(OFS_CTL_TWO, 32'haaaa);
		rdc(OFS_EVT_STATUS, 32'h100);
		chk(irq, 32'h0);
		apb(1'b1, OFS_EVT_MASK, 32'h100);
		cyc(2);
		chk(irq, 32'h1);
		apb(1'b1, OFS_EVT_STATUS, 32'h100);
		cyc(2);
		chk(irq, 32'h0);
		tdone("events");
		// Level mode: pins 0 and 5 pulse low, then software and core clear
		apb(1'b1, OFS_CTL_ONE, 32'h0);
		pins <= 8'hde;
		@(posedge clk);
		pins <= 8'hff;
		cyc(3);
		chk(flag, 32'h21);
		apb(1'b1, OFS_STATUS, 32'h0);
		cyc(1);
		chk(flag, 32'h21);
		rdc(OFS_STATUS, 32'h84);
		apb(1'b1, OFS_STATUS, 32'h04);
		cyc(1);
		chk(flag, 32'h20);
		pins <= 8'hdf;
		ack <= 1'b1;
		cyc(4);
		chk(flag, 32'h20);
		pins <= 8'hff;
		cyc(4);
		ack <= 1'b0;
		chk(flag, 32'h0);
		tdone("level");
		report_and_stop;
	end
endmodule
